// ### rtl/txm_tx_mod_ctrl.sv
`timescale 1ns/1ps
`include "txm_map.svh"

// ==========================================================
// Bit FIFO between host capture and the Gaussian ramp
module txm_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != CW'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end
endmodule

// ==========================================================
// Modulation and clock-out control
module txm_tx_mod_ctrl (
  // Clock and chip-enable reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  // Settings, taken on i_cfg_load once the regulator is ready
  input  wire logic               i_cfg_load,
  input  wire logic [3:0]         i_divided_ref_clock_out_divide_field,
  input  wire logic               i_divided_ref_clock_out_buffer_on,
  input  wire logic [8:0]         i_fsk_deviation_field,
  input  wire logic               i_mod_select_low_bit,
  input  wire logic               i_mod_select_high_bit,
  input  wire logic [2:0]         i_gauss_shift_exponent,
  input  wire logic               i_index_count_sel_low,
  input  wire logic               i_index_count_sel_high,
  input  wire logic [6:0]         i_gauss_rate_divider,
  input  wire logic [5:0]         i_output_power_level,
  input  wire logic               i_output_stage_on,
  input  wire logic [3:0]         i_osc_bias_field,
  input  wire logic [3:0]         i_status_select_field,
  input  wire txm_pkg::txm_div_type i_center_divider,
  // Host data link
  input  wire logic               i_tx_bit_input,
  output logic                    o_tx_sample_clock_out,
  output logic                    o_bit_fifo_ready,
  // Device outputs
  output logic                    o_divided_ref_clock_out,
  output logic                    o_status_mux_out,
  output txm_pkg::txm_div_type    o_eff_divider,
  output logic                    o_output_stage_en,
  output logic [5:0]              o_output_power_level,
  output logic [3:0]              o_osc_bias
);
  import txm_pkg::*;

  // ==========================================================
  // Regulator power-on and settings
  logic [11:0]      regon_cnt_r;
  logic             reg_ready_r;
  logic [3:0]       clkdiv_r;
  logic             clkbuf_r;
  logic [8:0]       dev_r;
  txm_mod_type      mode_r;
  logic [2:0]       shift_r;
  logic [1:0]       icsel_r;
  logic [6:0]       ratediv_r;
  logic [5:0]       pwr_r;
  logic             paon_r;
  logic [3:0]       bias_r;
  logic [3:0]       stsel_r;
  txm_div_type      center_r;
  logic             cfg_take;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      regon_cnt_r <= '0;
      reg_ready_r <= 1'b0;
    end
    else if (!reg_ready_r)
    begin
      regon_cnt_r <= regon_cnt_r + 12'h001;
      reg_ready_r <= (regon_cnt_r == 12'(`TXM_REGON_CYC - 1));
    end
  end

  // Loads before ready are dropped, as the host may not write yet.
  assign cfg_take = i_cfg_load & reg_ready_r;

  // Chip-enable low returns every setting to its power-up value.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      clkdiv_r  <= `TXM_CLKDIV_RST;
      clkbuf_r  <= `TXM_CLKBUF_RST;
      dev_r     <= `TXM_DEV_RST;
      mode_r    <= txm_mod_type'(`TXM_MODSEL_RST);
      shift_r   <= `TXM_SHIFT_RST;
      icsel_r   <= `TXM_ICSEL_RST;
      ratediv_r <= `TXM_RATEDIV_RST;
      pwr_r     <= `TXM_PWR_RST;
      paon_r    <= `TXM_PAON_RST;
      bias_r    <= `TXM_BIAS_RST;
      stsel_r   <= `TXM_STSEL_RST;
      center_r  <= `TXM_CENTER_RST;
    end
    else if (cfg_take)
    begin
      clkdiv_r  <= i_divided_ref_clock_out_divide_field;
      clkbuf_r  <= i_divided_ref_clock_out_buffer_on;
      dev_r     <= i_fsk_deviation_field;
      mode_r    <= txm_mod_type'({i_mod_select_high_bit, i_mod_select_low_bit});
      shift_r   <= i_gauss_shift_exponent;
      icsel_r   <= {i_index_count_sel_high, i_index_count_sel_low};
      ratediv_r <= i_gauss_rate_divider;
      pwr_r     <= i_output_power_level;
      paon_r    <= i_output_stage_on;
      bias_r    <= i_osc_bias_field;
      stsel_r   <= i_status_select_field;
      center_r  <= i_center_divider;
    end
  end

  // ==========================================================
  // Divided reference clock
  logic [3:0] clk_cnt_r;
  logic       clk_div_r;
  logic [3:0] half_m1;

  // A zero field is treated as the smallest ratio of two.
  assign half_m1 = (clkdiv_r == 4'h0) ? 4'h0 : clkdiv_r - 4'h1;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      clk_cnt_r <= '0;
      clk_div_r <= 1'b0;
    end
    else if (clk_cnt_r >= half_m1)
    begin
      // Toggling every field count gives ratio 2*field with equal halves.
      clk_cnt_r <= '0;
      clk_div_r <= ~clk_div_r;
    end
    else
    begin
      clk_cnt_r <= clk_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_divided_ref_clock_out <= 1'b0;
    end
    else
    begin
      o_divided_ref_clock_out <= clk_div_r & clkbuf_r;
    end
  end

  // ==========================================================
  // Data pin synchroniser
  logic tx_meta_r;
  logic tx_sync_r;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_meta_r <= 1'b0;
      tx_sync_r <= 1'b0;
    end
    else
    begin
      tx_meta_r <= i_tx_bit_input;
      tx_sync_r <= tx_meta_r;
    end
  end

  // ==========================================================
  // Gaussian sampling clock
  logic       gauss_mode;
  logic [6:0] pre_cnt_r;
  logic [6:0] rate_m1;
  logic       pre_tick;
  logic [7:0] idx_cnt_r;
  logic [7:0] idx_total;
  logic       bit_end;
  logic       tx_sample_clock_out_prev_r;
  logic       capture;

  assign gauss_mode = (mode_r == TXM_MOD_GFSK) || (mode_r == TXM_MOD_OOK);
  assign rate_m1    = (ratediv_r == 7'h00) ? 7'h00 : ratediv_r - 7'h01;
  assign pre_tick   = gauss_mode & (pre_cnt_r >= rate_m1);
  assign idx_total  = 8'(1 << (`TXM_IDX_BASE_LOG2 + int'(icsel_r)));
  assign bit_end    = pre_tick & (idx_cnt_r >= idx_total - 8'h01);

  // One bit lasts divider times index reference cycles.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pre_cnt_r <= '0;
      idx_cnt_r <= '0;
    end
    else if (!gauss_mode)
    begin
      pre_cnt_r <= '0;
      idx_cnt_r <= '0;
    end
    else if (pre_tick)
    begin
      pre_cnt_r <= '0;
      idx_cnt_r <= bit_end ? 8'h00 : idx_cnt_r + 8'h01;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // Low in the first half, so the host moves data on the fall.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_tx_sample_clock_out <= 1'b0;
      tx_sample_clock_out_prev_r          <= 1'b0;
    end
    else
    begin
      o_tx_sample_clock_out <= gauss_mode & (idx_cnt_r >= (idx_total >> 1));
      tx_sample_clock_out_prev_r          <= o_tx_sample_clock_out;
    end
  end

  // Mid-bit capture on the rising sample clock.
  assign capture = gauss_mode & o_tx_sample_clock_out & ~tx_sample_clock_out_prev_r;

  // ==========================================================
  // Bit FIFO and Gaussian ramp
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_bit;
  logic       fifo_pop;
  logic       target_r;
  logic [7:0] pos_r;

  // The ramp freezes while the output stage is off, so bits back up here.
  assign fifo_pop = bit_end & paon_r;

  txm_fifo #(
    .WIDTH (1),
    .DEPTH (`TXM_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (capture),
    .i_in_data   (tx_sync_r),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_bit),
    .i_out_ready (fifo_pop)
  );

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_bit_fifo_ready <= 1'b0;
      target_r         <= 1'b0;
    end
    else
    begin
      o_bit_fifo_ready <= fifo_in_ready;
      if (fifo_pop && fifo_out_valid)
      begin
        target_r <= fifo_out_bit;
      end
    end
  end

  // A linear ramp stands in for the filter's Gaussian taps; it keeps area small
  // while still spreading each transition over index-count steps.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pos_r <= '0;
    end
    else if (pos_r > idx_total)
    begin
      pos_r <= idx_total;
    end
    else if (pre_tick && paon_r)
    begin
      if (target_r && (pos_r < idx_total))
      begin
        pos_r <= pos_r + 8'h01;
      end
      else if (!target_r && (pos_r != 8'h00))
      begin
        pos_r <= pos_r - 8'h01;
      end
    end
  end

  // ==========================================================
  // Effective divider
  logic signed [19:0] ramp_t;
  logic signed [19:0] gauss_off;
  logic [3:0]         up_sh;
  logic [3:0]         dn_sh;
  txm_div_type        dev_ext;
  txm_div_type        eff_nxt;

  assign ramp_t    = $signed({11'h000, pos_r, 1'b0}) - $signed({12'h000, idx_total});
  assign up_sh     = {1'b0, shift_r} + 4'(`TXM_DEV_SHIFT);
  assign dn_sh     = {2'b00, icsel_r} + 4'(`TXM_IDX_BASE_LOG2);
  // Full swing is 4*2^m units of fpd/2^14, i.e. fpd*2^m/2^12.
  assign gauss_off = (ramp_t <<< up_sh) >>> dn_sh;
  assign dev_ext   = {15'h0000, dev_r};

  always_comb
  begin
    case (mode_r)
      TXM_MOD_FSK:  eff_nxt = tx_sync_r ? center_r + dev_ext : center_r - dev_ext;
      TXM_MOD_GFSK: eff_nxt = center_r + {{4{gauss_off[19]}}, gauss_off};
      default:      eff_nxt = center_r;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_eff_divider <= `TXM_CENTER_RST;
    end
    else
    begin
      o_eff_divider <= eff_nxt;
    end
  end

  // ==========================================================
  // Output stage and status
  logic st_nxt;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_output_stage_en    <= 1'b0;
      o_output_power_level <= `TXM_PWR_RST;
      o_osc_bias           <= `TXM_BIAS_RST;
    end
    else
    begin
      o_output_stage_en    <= paon_r & reg_ready_r;
      o_output_power_level <= pwr_r;
      o_osc_bias           <= bias_r;
    end
  end

  always_comb
  begin
    case (stsel_r)
      `TXM_ST_REGRDY: st_nxt = reg_ready_r;
      `TXM_ST_TXBIT:  st_nxt = tx_sync_r;
      `TXM_ST_DIVIDED_REF_CLOCK_OUT: st_nxt = clk_div_r;
      `TXM_ST_TX_SAMPLE_CLOCK_OUT:  st_nxt = o_tx_sample_clock_out;
      default:        st_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_status_mux_out <= 1'b0;
    end
    else
    begin
      o_status_mux_out <= st_nxt;
    end
  end
endmodule

// ### rtl/txm_map.svh
// Behaviour
// - Reference clock divided by even ratio 2-30, 50:50.
// - Ratio from four-bit field, defaults to sixteen.
// - Clock output buffer driven only when enabled.
// - Chip-enable low discards all programmed settings.
// - Status output defaults to regulator-ready flag.
// - Two-level keying samples data every reference cycle.
// - Data high adds deviation, low subtracts it.
// - Deviation is nine bits, step fpd/2^14.
// - Both select bits low choose two-level keying.
// - Gaussian keying ramps each transition in index steps.
// - Gaussian modes drive sampling clock to host.
// - Host changes data on fall; device captures on rise.
// - Gaussian deviation is fpd times 2^m over 2^12.
// - Sample rate is fpd over divider times index.
// - Six-bit output power level, zero is lowest.
// - Output stage off when its enable is low.
// - Four-bit selector picks status output source.
`ifndef TXM_MAP_SVH
`define TXM_MAP_SVH

// ==========================================================
// Power-up values
`define TXM_CLKDIV_RST    4'h8
`define TXM_CLKBUF_RST    1'b1
`define TXM_DEV_RST       9'h000
`define TXM_MODSEL_RST    2'h0
`define TXM_SHIFT_RST     3'h0
`define TXM_ICSEL_RST     2'h0
`define TXM_RATEDIV_RST   7'h01
`define TXM_PWR_RST       6'h00
`define TXM_PAON_RST      1'b0
`define TXM_BIAS_RST      4'h3
`define TXM_STSEL_RST     4'h0
`define TXM_CENTER_RST    24'h000000

// ==========================================================
// Status selector codes
`define TXM_ST_REGRDY     4'h0
`define TXM_ST_TXBIT      4'h1
`define TXM_ST_DIVIDED_REF_CLOCK_OUT     4'h2
`define TXM_ST_TX_SAMPLE_CLOCK_OUT      4'h3

// ==========================================================
// Field layout and timing
`define TXM_IDX_BASE_LOG2 4
`define TXM_DEV_SHIFT     2
`define TXM_FIFO_DEPTH    4
`define TXM_REF_PERIOD_NS 50
`define TXM_REGON_TIME_NS 100000
`define TXM_REGON_CYC     ((`TXM_REGON_TIME_NS + `TXM_REF_PERIOD_NS - 1) / `TXM_REF_PERIOD_NS)

`endif

// ### rtl/txm_pkg.sv
package txm_pkg;

  typedef enum logic [1:0]
  {
    TXM_MOD_FSK  = 2'h0,
    TXM_MOD_GFSK = 2'h1,
    TXM_MOD_ASK  = 2'h2,
    TXM_MOD_OOK  = 2'h3
  } txm_mod_type;

  typedef logic [23:0] txm_div_type;

endpackage

// ### bench/txm_mod_asserts.sv
`timescale 1ns/1ps

// ============================================================
// Port checker for the modulation control block
module txm_mod_asserts (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Settings
  input wire logic i_cfg_load,
  input wire logic [3:0] i_divided_ref_clock_out_divide_field,
  input wire logic i_divided_ref_clock_out_buffer_on,
  input wire logic [8:0] i_fsk_deviation_field,
  input wire logic i_mod_select_low_bit,
  input wire logic i_mod_select_high_bit,
  input wire logic i_index_count_sel_low,
  input wire logic i_index_count_sel_high,
  input wire logic [6:0] i_gauss_rate_divider,
  input wire logic [5:0] i_output_power_level,
  input wire logic i_output_stage_on,
  input wire txm_pkg::txm_div_type i_center_divider,
  input wire logic i_tx_bit_input,
  // Outputs
  input wire logic o_tx_sample_clock_out,
  input wire logic o_divided_ref_clock_out,
  input wire logic o_status_mux_out,
  input wire txm_pkg::txm_div_type o_eff_divider,
  input wire logic o_output_stage_en,
  input wire logic [5:0] o_output_power_level,
  input wire logic [3:0] o_osc_bias
);
  import txm_pkg::*;
  logic [11:0] cnt_r;
  logic [7:0]  since_r;
  logic [4:0]  crun_r;
  logic [13:0] trun_r;
  logic [13:0] prod_r;
  logic [3:0]  div_r;
  logic [8:0]  dev_r;
  logic        buf_r;
  logic        fsk_r;
  logic        gauss_r;
  txm_div_type ctr_r;
  logic        ld;

  // Loads are only trusted well after the regulator is up, so shadows never see a refused one.
  assign ld = i_cfg_load && cnt_r > 12'd2100;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_r   <= 12'h000;
      since_r <= 8'hFF;
    end
    else
    begin
      cnt_r   <= (cnt_r == 12'hFFF) ? cnt_r : cnt_r + 12'h001;
      since_r <= ld ? 8'h00 : ((since_r == 8'hFF) ? since_r : since_r + 8'h01);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      crun_r <= 5'h00;
      trun_r <= 14'h0000;
    end
    else
    begin
      crun_r <= $changed(o_divided_ref_clock_out) ? 5'h01 : crun_r + 5'h01;
      trun_r <= $changed(o_tx_sample_clock_out) ? 14'h0001 : trun_r + 14'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      div_r   <= 4'h8;
      buf_r   <= 1'b1;
      dev_r   <= 9'h000;
      ctr_r   <= 24'h000000;
      fsk_r   <= 1'b1;
      gauss_r <= 1'b0;
      prod_r  <= 14'h0010;
    end
    else if (ld)
    begin
      div_r   <= i_divided_ref_clock_out_divide_field;
      buf_r   <= i_divided_ref_clock_out_buffer_on;
      dev_r   <= i_fsk_deviation_field;
      ctr_r   <= i_center_divider;
      fsk_r   <= !i_mod_select_high_bit && !i_mod_select_low_bit;
      gauss_r <= i_mod_select_low_bit;
      prod_r  <= {3'h0, (i_gauss_rate_divider == 7'h00) ? 7'h01 : i_gauss_rate_divider, 4'h0}
                 << {i_index_count_sel_high, i_index_count_sel_low};
    end
  end

  AST_RESET_OUT: assert property ($fell(i_reset) |-> o_osc_bias == 4'h3 && !o_output_stage_en)
    else $error("outputs not at power-up values");
  AST_READY_WAIT: assert property (cnt_r < 12'd1990 |-> !o_status_mux_out && !o_output_stage_en)
    else $error("ready shown too early");
  AST_READY_HIGH: assert property (cnt_r == 12'd2010 && since_r == 8'hFF |-> o_status_mux_out)
    else $error("ready not shown by default");
  AST_DIVIDED_REF_CLOCK_OUT_HALF: assert property (buf_r && cnt_r > 12'd64 && since_r == 8'hFF && $changed(o_divided_ref_clock_out)
    |-> crun_r == ((div_r == 4'h0) ? 5'h01 : {1'b0, div_r}))
    else $error("clock out level time wrong");
  AST_DIVIDED_REF_CLOCK_OUT_GATED: assert property (!buf_r && since_r > 8'd3 |-> !o_divided_ref_clock_out)
    else $error("clock out driven while disabled");
  AST_PWR_LEVEL: assert property (ld |-> ##3 o_output_power_level == $past(i_output_power_level, 3))
    else $error("power level not applied");
  AST_STAGE_EN: assert property (ld |-> ##3 o_output_stage_en == $past(i_output_stage_on, 3))
    else $error("output stage enable wrong");
  AST_FSK_HIGH: assert property (i_tx_bit_input [*6] ##0 fsk_r && since_r > 8'd8
    |-> o_eff_divider == ctr_r + 24'(dev_r))
    else $error("high tone divider wrong");
  AST_FSK_LOW: assert property ((!i_tx_bit_input) [*6] ##0 fsk_r && since_r > 8'd8
    |-> o_eff_divider == ctr_r - 24'(dev_r))
    else $error("low tone divider wrong");
  AST_TX_SAMPLE_CLOCK_OUT_IDLE: assert property (!gauss_r && since_r > 8'd3 |-> !o_tx_sample_clock_out)
    else $error("sample clock outside filtered modes");
  AST_TX_SAMPLE_CLOCK_OUT_HALF: assert property (gauss_r && since_r == 8'hFF && $changed(o_tx_sample_clock_out)
    |-> trun_r == prod_r[13:1])
    else $error("sample clock level time wrong");

  cover property (ld && gauss_r);
  cover property (fsk_r && $rose(i_tx_bit_input));
  cover property (!buf_r && since_r == 8'hFF);
endmodule

bind txm_tx_mod_ctrl txm_mod_asserts u_asserts (.*);

// ### bench/txm_host_model.sv
`timescale 1ns/1ps

// ============================================================
// Host side of the transmit data link
module txm_host_model (
  // Clocks
  input  wire logic       i_ref_clk,
  input  wire logic       i_tx_sample_clock_out,
  // Bench controls
  input  wire logic       i_sync_mode,
  input  wire logic       i_level,
  input  wire logic [7:0] i_pattern,
  // Data pin
  output logic            o_tx_bit_input
);
  logic       clk_q;
  logic [2:0] idx;

  initial
  begin
    o_tx_bit_input = 1'b0;
    clk_q = 1'b0;
    idx = 3'h0;
  end

  // A new bit leaves on the sampling clock's fall, so it is settled for half a bit before capture.
  always @(negedge i_ref_clk)
  begin
    clk_q <= i_tx_sample_clock_out;
    if (!i_sync_mode)
    begin
      o_tx_bit_input <= i_level;
      idx <= 3'h0;
    end
    else if (clk_q && !i_tx_sample_clock_out)
    begin
      o_tx_bit_input <= i_pattern[idx];
      idx <= idx + 3'h1;
    end
  end
endmodule

// ### bench/txm_tx_mod_ctrl_tb_top.sv
`timescale 1ns/1ps

// ============================================================
// Bench top
module txm_tx_mod_ctrl_tb_top;
  import txm_pkg::*;
  logic        i_ref_clk, i_reset, i_cfg_load, i_divided_ref_clock_out_buffer_on, i_output_stage_on;
  logic        i_mod_select_low_bit, i_mod_select_high_bit, i_index_count_sel_low, i_index_count_sel_high;
  logic [3:0]  i_divided_ref_clock_out_divide_field, i_osc_bias_field, i_status_select_field, o_osc_bias;
  logic [8:0]  i_fsk_deviation_field;
  logic [2:0]  i_gauss_shift_exponent;
  logic [6:0]  i_gauss_rate_divider;
  logic [5:0]  i_output_power_level, o_output_power_level;
  txm_div_type i_center_divider, o_eff_divider;
  logic        i_tx_bit_input, o_tx_sample_clock_out, o_bit_fifo_ready, o_divided_ref_clock_out;
  logic        o_status_mux_out, o_output_stage_en, sync_mode, level;
  logic [7:0]  pattern;
  logic [23:0] n;
  int          mismatches, total_checks;

  txm_tx_mod_ctrl dut (.*);
  txm_host_model host (.i_ref_clk, .i_tx_sample_clock_out(o_tx_sample_clock_out), .i_sync_mode(sync_mode),
                       .i_level(level), .i_pattern(pattern), .o_tx_bit_input(i_tx_bit_input));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge i_ref_clk);
  endtask

  // Settings can only be written once the regulator reports ready, so every reset waits it out.
  task automatic do_reset();
    i_reset = 1'b1;
    cycles(12);
    i_reset = 1'b0;
    cycles(2200);
  endtask

  task automatic load(input logic [1:0] mode);
    {i_mod_select_high_bit, i_mod_select_low_bit} = mode;
    i_cfg_load = 1'b1;
    cycles(1);
    i_cfg_load = 1'b0;
    cycles(4);
  endtask

  function automatic logic sig(input logic sel);
    return sel ? o_tx_sample_clock_out : o_divided_ref_clock_out;
  endfunction

  task automatic high_len(input logic sel);
    n = 24'h0;
    repeat (300) if (sig(sel)) @(negedge i_ref_clk);
    repeat (300) if (!sig(sel)) @(negedge i_ref_clk);
    while (sig(sel) && n < 24'd300)
    begin
      n++;
      @(negedge i_ref_clk);
    end
  endtask

  task automatic t_divided_ref_clock_out();
    high_len(1'b0);
    check(n, 24'd8);
    check(o_status_mux_out, 1'b1);
    for (int f = 1; f < 16; f += 14)
    begin
      i_divided_ref_clock_out_divide_field = 4'(f);
      load(2'h0);
      high_len(1'b0);
      check(n, 24'(f));
    end
    i_divided_ref_clock_out_buffer_on = 1'b0;
    load(2'h0);
    n = 24'h0;
    repeat (40) @(negedge i_ref_clk) n[0] |= o_divided_ref_clock_out;
    check(n, 24'h0);
    i_divided_ref_clock_out_buffer_on = 1'b1;
    $display("clock out test done");
  endtask

  task automatic t_fsk();
    i_center_divider = 24'h100000;
    i_fsk_deviation_field = 9'h1FF;
    load(2'h0);
    for (int b = 0; b < 2; b++)
    begin
      level = b[0];
      cycles(6);
      check(o_eff_divider, b ? 24'h1001FF : 24'h0FFE01);
    end
    load(2'h2);
    check(o_tx_sample_clock_out, 1'b0);
    i_status_select_field = 4'h1;
    load(2'h0);
    level = 1'b0;
    cycles(6);
    check(o_status_mux_out, 1'b0);
    i_status_select_field = 4'h0;
    $display("keying test done");
  endtask

  task automatic t_gauss();
    i_output_power_level = 6'h3F;
    i_output_stage_on = 1'b0;
    pattern = 8'hFF;
    sync_mode = 1'b1;
    load(2'h1);
    check(o_output_power_level, 6'h3F);
    check(o_output_stage_en, 1'b0);
    high_len(1'b1);
    check(n, 24'd8);
    cycles(128);
    check(o_bit_fifo_ready, 1'b0);
    i_output_stage_on = 1'b1;
    load(2'h1);
    check(o_output_stage_en, 1'b1);
    repeat (40) if (!o_bit_fifo_ready) @(negedge i_ref_clk);
    check(o_bit_fifo_ready, 1'b1);
    cycles(320);
    check(o_eff_divider, 24'h100020);
    pattern = 8'h00;
    cycles(320);
    check(o_eff_divider, 24'h0FFFE0);
    i_gauss_rate_divider = 7'h02;
    i_index_count_sel_low = 1'b1;
    load(2'h3);
    high_len(1'b1);
    check(n, 24'd32);
    sync_mode = 1'b0;
    $display("filtered keying test done");
  endtask

  task automatic t_reset_mid();
    do_reset();
    check(o_output_power_level, 6'h00);
    check(o_output_stage_en, 1'b0);
    check(o_eff_divider, 24'h0);
    check(o_status_mux_out, 1'b1);
    $display("reset test done");
  endtask

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {i_reset, i_cfg_load, i_divided_ref_clock_out_buffer_on, i_output_stage_on, sync_mode, level} = 6'h28;
    {i_mod_select_low_bit, i_mod_select_high_bit, i_index_count_sel_low, i_index_count_sel_high} = 4'h0;
    i_divided_ref_clock_out_divide_field = 4'h8;
    i_osc_bias_field = 4'h4;
    i_status_select_field = 4'h0;
    i_fsk_deviation_field = 9'h000;
    i_gauss_shift_exponent = 3'h3;
    i_gauss_rate_divider = 7'h01;
    i_output_power_level = 6'h00;
    i_center_divider = 24'h0;
    pattern = 8'h00;
    mismatches = 0;
    total_checks = 0;
    do_reset();
    t_divided_ref_clock_out();
    t_fsk();
    t_gauss();
    t_reset_mid();
    print_verdict();
  end
endmodule
